// File: hw/cat_cfg.svh
`ifndef CAT_CFG_SVH
`define CAT_CFG_SVH
// sfr addresses of the counter array
`define CAT_ADDR_CTRL      8'hd8
`define CAT_ADDR_MODE      8'hd9
`define CAT_ADDR_CNT_LO    8'he9
`define CAT_ADDR_CNT_HI    8'hf9
`define CAT_ADDR_CPM0      8'hda
`define CAT_ADDR_CPL_BASE  8'he0
`define CAT_ADDR_CPH_BASE  8'hf0
// control register fields
`define CAT_CTRL_WRAP      7
`define CAT_CTRL_RUN       6
`define CAT_CTRL_RESET     8'h00
`define CAT_CTRL_UNUSED    5
`define CAT_CTRL_MASK      8'hdf
`define CAT_CNT_MAX        16'hffff
// mode register fields
`define CAT_MODE_IDLE      7
`define CAT_MODE_IRQ       0
`define CAT_MODE_SEL_LO    1
`define CAT_MODE_RESET     8'h00
// module mode register fields
`define CAT_CPM_COMP       6
`define CAT_CPM_MATCH      3
`define CAT_CPM_TOGGLE     2
`define CAT_CPM_IRQ        0
// timebase dividers
`define CAT_DIV12          4'hb
`define CAT_DIV4           4'h3
`define CAT_XDIV8          3'h7
`define CAT_NMOD           5
`endif

// File: hw/cat_pkg.sv
package cat_pkg;
   typedef enum logic [2:0] {
      CAT_TB_DIV12 = 3'h0,
      CAT_TB_DIV4  = 3'h1,
      CAT_TB_T0    = 3'h2,
      CAT_TB_EXT   = 3'h3,
      CAT_TB_SYS   = 3'h4,
      CAT_TB_XOSC  = 3'h5
   } cat_tb_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cat_sfr_req_t;

   typedef struct packed {
      logic [2:0] sync;
      logic       lvl;
   } cat_sync_t;
endpackage

// File: hw/cat_pin_sync.sv
`timescale 1ns/1ps
module cat_pin_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      fall,
   output logic      rise
);
   cat_pkg::cat_sync_t s_q;
   cat_pkg::cat_sync_t s_d;

   always_comb begin
      s_d.sync = {s_q.sync[1:0], pin};
      s_d.lvl  = s_q.lvl;
      if (s_q.sync[2] == s_q.sync[1]) begin
         s_d.lvl = s_q.sync[2];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign fall = s_q.lvl & ~s_d.lvl;
   assign rise = ~s_q.lvl & s_d.lvl;
endmodule // cat_pin_sync

// File: hw/cat_array.sv
`timescale 1ns/1ps
`include "cat_cfg.svh"
// How it works
// - low read snapshots high byte
// - byte reads never disturb counting
// - three-bit select picks count source
// - count external input falling edges
// - external oscillator synchronised before counting
// - wrap ffff to zero sets flag
// - wrap flag interrupt gated by enable
// - wrap flag cleared only by software
// - need global and array irq enables
// - idle suspend clear keeps counting
// - output toggles on every compare match
// - toggle, match, comparator enable active
// - low write clears, high sets comparator
// - per-module event flags need software clear
// - control bit five reads zero
module cat_array (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire cat_pkg::cat_sfr_req_t sfr,
   output logic [7:0]                rdata,
   input  wire logic                 cpu_idle,
   input  wire logic                 global_irq_enable,
   input  wire logic                 array_irq_enable,
   input  wire logic                 timer0_overflow,
   input  wire logic                 external_count_input,
   input  wire logic                 ext_osc,
   output logic                      irq,
   output logic [4:0]                module_output_pin
);
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  mode;
      logic [15:0] cnt;
      logic [7:0]  snap;
      logic [3:0]  div;
      logic [2:0]  xdiv;
      logic [39:0] cpm;
      logic [79:0] cmp;
      logic [4:0]  pin;
      logic [7:0]  rd;
   } cat_state_t;

   cat_state_t st_q;
   cat_state_t st_d;
   logic       ext_fall;
   logic       xosc_rise;
   logic       tick;
   logic       step;
   logic       wrap;
   logic [4:0] hit;
   logic [2:0] sel;

   function automatic logic is_cpl(input logic [7:0] a, input int m);
      return a == (`CAT_ADDR_CPL_BASE + 8'(m));
   endfunction

   function automatic logic is_cph(input logic [7:0] a, input int m);
      return a == (`CAT_ADDR_CPH_BASE + 8'(m));
   endfunction

   cat_pin_sync u_ext (
      .clk  (clk),
      .rst_n(rst_n),
      .pin  (external_count_input),
      .fall (ext_fall),
      .rise ()
   );

   cat_pin_sync u_xosc (
      .clk  (clk),
      .rst_n(rst_n),
      .pin  (ext_osc),
      .fall (),
      .rise (xosc_rise)
   );

   always_comb begin
      st_d = st_q;
      sel  = st_q.mode[`CAT_MODE_SEL_LO +: 3];
      tick = 1'b0;
      st_d.div = (st_q.div == `CAT_DIV12) ? 4'h0 : st_q.div + 4'h1;
      if (xosc_rise) begin
         st_d.xdiv = st_q.xdiv + 3'h1;
      end
      unique case (cat_pkg::cat_tb_t'(sel))
         cat_pkg::CAT_TB_DIV12: tick = (st_q.div == `CAT_DIV12);
         cat_pkg::CAT_TB_DIV4:  tick = (st_q.div[1:0] == 2'(`CAT_DIV4));
         cat_pkg::CAT_TB_T0:    tick = timer0_overflow;
         cat_pkg::CAT_TB_EXT:   tick = ext_fall;
         cat_pkg::CAT_TB_SYS:   tick = 1'b1;
         cat_pkg::CAT_TB_XOSC:  tick = xosc_rise && (st_q.xdiv == `CAT_XDIV8);
         default:               tick = 1'b0;
      endcase
      step = tick && st_q.ctrl[`CAT_CTRL_RUN] && !(st_q.mode[`CAT_MODE_IDLE] && cpu_idle);
      wrap = step && (st_q.cnt == `CAT_CNT_MAX);
      if (step) begin
         st_d.cnt = st_q.cnt + 16'h0001;
      end
      st_d.rd = 8'h00;
      if (sfr.rd) begin
         unique case (sfr.addr)
            `CAT_ADDR_CTRL:   st_d.rd = st_q.ctrl & `CAT_CTRL_MASK;
            `CAT_ADDR_MODE:   st_d.rd = st_q.mode;
            `CAT_ADDR_CNT_LO: begin
               st_d.rd   = st_q.cnt[7:0];
               st_d.snap = st_q.cnt[15:8];
            end
            `CAT_ADDR_CNT_HI: st_d.rd = st_q.snap;
            default: begin
               for (int m = 0; m < `CAT_NMOD; m++) begin
                  if (sfr.addr == `CAT_ADDR_CPM0 + 8'(m)) st_d.rd = st_q.cpm[8*m +: 8];
                  if (is_cpl(sfr.addr, m)) st_d.rd = st_q.cmp[16*m +: 8];
                  if (is_cph(sfr.addr, m)) st_d.rd = st_q.cmp[16*m+8 +: 8];
               end
            end
         endcase
      end
      if (sfr.wr) begin
         if (sfr.addr == `CAT_ADDR_CTRL) st_d.ctrl = sfr.wdata & `CAT_CTRL_MASK;
         if (sfr.addr == `CAT_ADDR_MODE) st_d.mode = sfr.wdata;
         if (sfr.addr == `CAT_ADDR_CNT_LO) st_d.cnt[7:0] = sfr.wdata;
         if (sfr.addr == `CAT_ADDR_CNT_HI) st_d.cnt[15:8] = sfr.wdata;
         for (int m = 0; m < `CAT_NMOD; m++) begin
            if (sfr.addr == `CAT_ADDR_CPM0 + 8'(m)) st_d.cpm[8*m +: 8] = sfr.wdata;
            if (is_cpl(sfr.addr, m)) begin
               st_d.cmp[16*m +: 8] = sfr.wdata;
               st_d.cpm[8*m + `CAT_CPM_COMP] = 1'b0;
            end
            if (is_cph(sfr.addr, m)) begin
               st_d.cmp[16*m+8 +: 8] = sfr.wdata;
               st_d.cpm[8*m + `CAT_CPM_COMP] = 1'b1;
            end
         end
      end
      for (int m = 0; m < `CAT_NMOD; m++) begin
         hit[m] = step && st_q.cpm[8*m + `CAT_CPM_COMP] && st_q.cpm[8*m + `CAT_CPM_MATCH]
                  && (st_d.cnt == st_q.cmp[16*m +: 16]);
         if (hit[m]) begin
            st_d.ctrl[m] = 1'b1;
            if (st_q.cpm[8*m + `CAT_CPM_TOGGLE]) begin
               st_d.pin[m] = ~st_q.pin[m];
            end
         end
      end
      if (wrap) begin
         st_d.ctrl[`CAT_CTRL_WRAP] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q      <= '0;
         st_q.ctrl <= `CAT_CTRL_RESET;
         st_q.mode <= `CAT_MODE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   logic irq_src;
   always_comb begin
      irq_src = st_q.ctrl[`CAT_CTRL_WRAP] && st_q.mode[`CAT_MODE_IRQ];
      for (int m = 0; m < `CAT_NMOD; m++) begin
         irq_src = irq_src || (st_q.ctrl[m] && st_q.cpm[8*m + `CAT_CPM_IRQ]);
      end
   end

   assign irq               = irq_src && global_irq_enable && array_irq_enable;
   assign rdata             = st_q.rd;
   assign module_output_pin = st_q.pin;

   // snapshot pair: low read, idle cycle, high read
   sequence s_low_read;
      sfr.rd && sfr.addr == `CAT_ADDR_CNT_LO;
   endsequence

   sequence s_high_read;
      sfr.rd && sfr.addr == `CAT_ADDR_CNT_HI;
   endsequence

   chk_wrap_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
      wrap |=> st_q.ctrl[`CAT_CTRL_WRAP]) else $error("wrap flag not set");
   chk_flag_holds: assert property (@(posedge clk) disable iff (!rst_n)
      st_q.ctrl[`CAT_CTRL_WRAP] && !(sfr.wr && sfr.addr == `CAT_ADDR_CTRL)
      |=> st_q.ctrl[`CAT_CTRL_WRAP]) else $error("wrap flag lost");
   chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
      irq |-> global_irq_enable && array_irq_enable) else $error("irq ungated");
   chk_irq_wrap: assert property (@(posedge clk) disable iff (!rst_n)
      st_q.ctrl[`CAT_CTRL_WRAP] && st_q.mode[`CAT_MODE_IRQ] && global_irq_enable
      && array_irq_enable |-> irq) else $error("wrap irq missing");
   chk_bit5_zero: assert property (@(posedge clk) disable iff (!rst_n)
      !st_q.ctrl[`CAT_CTRL_UNUSED]) else $error("bit five set");
   chk_run_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !st_q.ctrl[`CAT_CTRL_RUN] && !sfr.wr |=> $stable(st_q.cnt)) else $error("count moved");
   chk_idle_hold: assert property (@(posedge clk) disable iff (!rst_n)
      st_q.mode[`CAT_MODE_IDLE] && cpu_idle && !sfr.wr |=> $stable(st_q.cnt))
      else $error("count moved in idle");
   chk_snap_read: assert property (@(posedge clk) disable iff (!rst_n)
      s_low_read |=> st_q.snap == $past(st_q.cnt[15:8])) else $error("snapshot wrong");
   chk_snap_pair: assert property (@(posedge clk) disable iff (!rst_n)
      s_low_read ##1 !sfr.rd ##1 s_high_read |=> rdata == $past(st_q.cnt[15:8], 3))
      else $error("high byte not from snapshot");
   chk_sys_count: assert property (@(posedge clk) disable iff (!rst_n)
      sel == 3'h4 && step && !sfr.wr |=> st_q.cnt == $past(st_q.cnt) + 16'h0001)
      else $error("count step wrong");
   chk_cpl_clears: assert property (@(posedge clk) disable iff (!rst_n)
      sfr.wr && sfr.addr == `CAT_ADDR_CPL_BASE |=> !st_q.cpm[`CAT_CPM_COMP])
      else $error("comparator not cleared");
   chk_cph_sets: assert property (@(posedge clk) disable iff (!rst_n)
      sfr.wr && sfr.addr == `CAT_ADDR_CPH_BASE |=> st_q.cpm[`CAT_CPM_COMP])
      else $error("comparator not set");
   chk_event_set: assert property (@(posedge clk) disable iff (!rst_n)
      hit[1] |=> st_q.ctrl[1]) else $error("event flag not set");
   chk_event_held: assert property (@(posedge clk) disable iff (!rst_n)
      st_q.ctrl[0] && !(sfr.wr && sfr.addr == `CAT_ADDR_CTRL) |=> st_q.ctrl[0])
      else $error("event flag lost");
   chk_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      hit[0] && st_q.cpm[`CAT_CPM_TOGGLE] |=> module_output_pin[0] != $past(st_q.pin[0]))
      else $error("no toggle");
endmodule // cat_array

// File: tb/cat_array_tb.sv
`timescale 1ns/1ps
module cat_array_tb;
   logic                  clk;
   logic                  rst_n;
   cat_pkg::cat_sfr_req_t sfr;
   logic [7:0]            rdata;
   logic                  cpu_idle;
   logic                  global_irq_enable;
   logic                  array_irq_enable;
   logic                  timer0_overflow;
   logic                  external_count_input;
   logic                  ext_osc;
   logic                  irq;
   logic [4:0]            module_output_pin;
   int                    fail_count;
   int                    samples_checked;
   logic [7:0]            l;
   logic [7:0]            h;
   logic [7:0]            b;
   logic [15:0]           w;

   cat_array cat_array_inst (
      .clk                  (clk),
      .rst_n                (rst_n),
      .sfr                  (sfr),
      .rdata                (rdata),
      .cpu_idle             (cpu_idle),
      .global_irq_enable    (global_irq_enable),
      .array_irq_enable     (array_irq_enable),
      .timer0_overflow      (timer0_overflow),
      .external_count_input (external_count_input),
      .ext_osc              (ext_osc),
      .irq                  (irq),
      .module_output_pin    (module_output_pin)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // range compare, exact when lo equals hi
   task automatic check(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      samples_checked++;
      if (((got >= lo) && (got <= hi)) !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      sfr.wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      sfr.rd = 1'b0;
      d = rdata;
   endtask

   // run the counter for len cycles plus a six-cycle drain on one timebase and check the advance
   task automatic measure(input logic [7:0] mode, input logic idle, input int len,
                          input logic [15:0] lo, input logic [15:0] hi);
      logic [7:0]  sl;
      logic [7:0]  sh;
      logic [15:0] a;
      wr(8'hd9, mode);
      rd(8'he9, sl);
      rd(8'hf9, sh);
      a = {sh, sl};
      cpu_idle = idle;
      wr(8'hd8, 8'h40);
      for (int i = 0; i < len; i++) begin
         timer0_overflow = (i % 4 == 0);
         external_count_input = i[2];
         ext_osc = i[3];
         @(negedge clk);
      end
      timer0_overflow = 1'b0;
      external_count_input = 1'b0;
      ext_osc = 1'b0;
      repeat (6) @(negedge clk);
      wr(8'hd8, 8'h00);
      cpu_idle = 1'b0;
      rd(8'he9, sl);
      rd(8'hf9, sh);
      check({sh, sl} - a, lo, hi);
   endtask

   initial begin
      fail_count = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      sfr = '0;
      cpu_idle = 1'b0;
      global_irq_enable = 1'b0;
      array_irq_enable = 1'b0;
      timer0_overflow = 1'b0;
      external_count_input = 1'b0;
      ext_osc = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      rd(8'hd8, b);
      check({8'h00, b}, 16'h0000, 16'h0000);
      rd(8'hd9, b);
      check({8'h00, b}, 16'h0000, 16'h0000);
      check({11'h000, module_output_pin}, 16'h0000, 16'h0000);
      wr(8'hd8, 8'h20);
      rd(8'hd8, b);
      check({8'h00, b}, 16'h0000, 16'h0000);
      measure(8'h08, 1'b0, 400, 16'h0197, 16'h0199);
      measure(8'h02, 1'b0, 400, 16'h0065, 16'h0067);
      measure(8'h00, 1'b0, 1200, 16'h0063, 16'h0066);
      measure(8'h04, 1'b0, 400, 16'h0063, 16'h0065);
      measure(8'h06, 1'b0, 400, 16'h0031, 16'h0033);
      measure(8'h0a, 1'b0, 1600, 16'h000b, 16'h000e);
      measure(8'h88, 1'b1, 400, 16'h0000, 16'h0000);
      measure(8'h08, 1'b1, 400, 16'h0197, 16'h0199);
      wr(8'hd8, 8'h40);
      rd(8'he9, l);
      rd(8'hf9, h);
      repeat (600) @(negedge clk);
      rd(8'hf9, b);
      check({8'h00, b}, {8'h00, h}, {8'h00, h});
      w = {h, l};
      rd(8'he9, l);
      rd(8'hf9, h);
      check({h, l} - w, 16'h025e, 16'h025e);
      wr(8'hd8, 8'h00);
      wr(8'hda, 8'h4d);
      wr(8'he0, 8'h10);
      rd(8'hda, b);
      check({8'h00, b}, 16'h000d, 16'h000d);
      wr(8'hf0, 8'h00);
      rd(8'hda, b);
      check({8'h00, b}, 16'h004d, 16'h004d);
      wr(8'hdb, 8'h48);
      wr(8'he1, 8'h10);
      wr(8'hf1, 8'h00);
      wr(8'he9, 8'he0);
      wr(8'hf9, 8'hff);
      rd(8'he9, l);
      rd(8'hf9, h);
      check({h, l}, 16'hffe0, 16'hffe0);
      wr(8'hd9, 8'h09);
      global_irq_enable = 1'b1;
      array_irq_enable = 1'b1;
      wr(8'hd8, 8'h40);
      b = 8'h00;
      for (int i = 0; i < 200 && b[7] !== 1'b1; i++) begin
         rd(8'hd8, b);
      end
      check({15'h0000, b[7]}, 16'h0001, 16'h0001);
      repeat (40) @(negedge clk);
      rd(8'hd8, b);
      check({8'h00, b}, 16'h00c3, 16'h00c3);
      check({11'h000, module_output_pin}, 16'h0001, 16'h0001);
      check({15'h0000, irq}, 16'h0001, 16'h0001);
      wr(8'hda, 8'h4c);
      wr(8'hd9, 8'h08);
      check({15'h0000, irq}, 16'h0000, 16'h0000);
      wr(8'hd9, 8'h09);
      check({15'h0000, irq}, 16'h0001, 16'h0001);
      global_irq_enable = 1'b0;
      @(negedge clk);
      check({15'h0000, irq}, 16'h0000, 16'h0000);
      global_irq_enable = 1'b1;
      array_irq_enable = 1'b0;
      @(negedge clk);
      check({15'h0000, irq}, 16'h0000, 16'h0000);
      array_irq_enable = 1'b1;
      @(negedge clk);
      check({15'h0000, irq}, 16'h0001, 16'h0001);
      rd(8'hd8, b);
      check({8'h00, b}, 16'h00c3, 16'h00c3);
      wr(8'hd8, 8'h40);
      rd(8'hd8, b);
      check({8'h00, b}, 16'h0040, 16'h0040);
      check({15'h0000, irq}, 16'h0000, 16'h0000);
      conclude();
   end
endmodule // cat_array_tb
